//--- rtl/cdl_select_limit.sv
// Current demand selection, trim and limiting ahead of the current loop.
// Assumes loop inputs are synchronous to clk_sys_i and a control update is one clock.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module cdl_select_limit
	import cdl_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = CYC_PER_S
)(
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire logic [4:0]           addr_i,
	input  wire logic [15:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [15:0]          rdata_o,
	input  wire cdl_loop_in_t         loop_i,
	input  wire logic                 run_i,
	output logic signed [DW-1:0]      final_demand_o,
	output logic signed [DW-1:0]      speed_ref_o,
	output logic                      zero_speed_ref_o
);

	logic        [LW-1:0] sym_lim_r;
	logic        [LW-1:0] pos_lim_r;
	logic        [LW-1:0] neg_lim_r;
	logic        [LW-1:0] lim2_r;
	logic signed [DW-1:0] torque_r;
	logic signed [DW-1:0] trim_r;
	logic                 lim2_sel_r;
	logic                 trim_sel_r;
	logic                 mode_lo_r;
	logic                 mode_hi_r;
	logic                 auto_en_r;
	logic        [7:0]    lim2_time_r;
	logic signed [DW-1:0] demand_r;
	logic signed [DW-1:0] final_r;
	logic        [LW-1:0] over_r;
	logic        [31:0]   sec_cnt_r;
	logic        [7:0]    sec_r;
	logic                 timing_r;
	logic                 run_d_r;
	logic                 auto_set;
	cdl_mode_t            mode;

	logic signed [DW-1:0] demand_nxt;
	logic signed [DW-1:0] final_nxt;
	logic        [LW-1:0] over_nxt;
	logic signed [DW-1:0] speed_ref_nxt;
	logic                 zero_ref_nxt;

	// Saturating keeps an overflow from flipping the sign of a demand.
	function automatic logic signed [DW-1:0] sat(input logic signed [DW+1:0] v);
		if (v > DMAX)
			return DMAX;
		else if (v < DMIN)
			return DMIN;
		else
			return v[DW-1:0];
	endfunction

	function automatic logic [LW-1:0] umin(input logic [LW-1:0] a, input logic [LW-1:0] b);
		return (a < b) ? a : b;
	endfunction

	// A written limit is compared as a whole word, so a large value cannot wrap into a small limit.
	function automatic logic [LW-1:0] lim_clip(input logic [15:0] d);
		if (d > {6'h00, LIM_RST})
			return LIM_RST;
		else
			return d[LW-1:0];
	endfunction

	// The bit order here makes mode_lo weigh 1, so 01 in the written pair means torque.
	assign mode = cdl_mode_t'({mode_hi_r, mode_lo_r});

	// Limits are unsigned magnitudes; the symmetric and limit-two values apply to either sign, pos and neg to one sign each.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sym_lim_r <= LIM_RST;
			pos_lim_r <= LIM_RST;
			neg_lim_r <= LIM_RST;
			lim2_r    <= LIM_RST;
		end
		else if (wr_i)
		begin
			case (addr_i)
				A_SYM_LIM: sym_lim_r <= lim_clip(wdata_i);
				A_POS_LIM: pos_lim_r <= lim_clip(wdata_i);
				A_NEG_LIM: neg_lim_r <= lim_clip(wdata_i);
				A_LIM2:    lim2_r    <= lim_clip(wdata_i);
				default:   ;
			endcase
		end
	end

	// Signed writes carry an 11-bit two's complement value and saturate at the range ends.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			torque_r <= ZERO_D;
			trim_r   <= ZERO_D;
		end
		else if (wr_i)
		begin
			case (addr_i)
				A_TORQUE: torque_r <= sat({{2{wdata_i[DW-1]}}, wdata_i[DW-1:0]});
				A_TRIM:   trim_r   <= sat({{2{wdata_i[DW-1]}}, wdata_i[DW-1:0]});
				default:  ;
			endcase
		end
	end

	// Mode, trim select and timer settings; the limit-two select bit has its own process.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			trim_sel_r  <= 1'b0;
			mode_lo_r   <= 1'b0;
			mode_hi_r   <= 1'b0;
			auto_en_r   <= 1'b0;
			lim2_time_r <= 8'h00;
		end
		else if (wr_i)
		begin
			case (addr_i)
				A_TRIM_SEL:  trim_sel_r  <= wdata_i[0];
				A_MODE_LO:   mode_lo_r   <= wdata_i[0];
				A_MODE_HI:   mode_hi_r   <= wdata_i[0];
				A_AUTO_EN:   auto_en_r   <= wdata_i[0];
				A_LIM2_TIME: lim2_time_r <= wdata_i[7:0];
				default:     ;
			endcase
		end
	end

	// Automatic selection wins over a software write in the same cycle.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			lim2_sel_r <= 1'b0;
		else if (auto_set)
			lim2_sel_r <= 1'b1;
		else if (wr_i && addr_i == A_LIM2_SEL)
			lim2_sel_r <= wdata_i[0];
	end

	// Seconds timer started by the rising edge of run; run from other logic is synchronous.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			run_d_r   <= 1'b0;
			timing_r  <= 1'b0;
			sec_cnt_r <= '0;
			sec_r     <= 8'h00;
		end
		else
		begin
			run_d_r <= run_i;
			if (run_i && !run_d_r)
			begin
				timing_r  <= 1'b1;
				sec_cnt_r <= '0;
				sec_r     <= 8'h00;
			end
			else if (!run_i || auto_set)
				timing_r <= 1'b0;
			else if (timing_r)
			begin
				if (sec_cnt_r == SEC_CYCLES - 1)
				begin
					sec_cnt_r <= '0;
					sec_r     <= sec_r + 8'h01;
				end
				else
					sec_cnt_r <= sec_cnt_r + 32'h1;
			end
		end
	end

	assign auto_set = auto_en_r && timing_r && run_i && (sec_r >= lim2_time_r);

	always_comb
	begin
		logic signed [DW-1:0] sel;
		logic signed [DW-1:0] plim;
		logic signed [DW-1:0] nlim;
		logic                 regen;
		sel           = loop_i.speed_out;
		speed_ref_nxt = loop_i.speed_dem;
		zero_ref_nxt  = 1'b0;
		regen         = 1'b0;
		plim          = '0;
		nlim          = '0;
		// The taper result already starts from the symmetric limit, so the lower of the two stands.
		over_nxt      = umin(loop_i.taper_lim, sym_lim_r);
		if (lim2_sel_r)
			over_nxt = umin(over_nxt, lim2_r);
		case (mode)
			CDL_SPEED:
				sel = loop_i.speed_out;
			CDL_TORQUE:
				sel = torque_r;
			CDL_OVERRIDE:
			begin
				// Speed output may follow the torque reference only when error agrees in sign.
				if ((loop_i.speed_err[DW-1] == torque_r[DW-1]) && loop_i.speed_err != ZERO_D)
				begin
					if (torque_r[DW-1])
						sel = (loop_i.speed_out < torque_r) ? torque_r : loop_i.speed_out;
					else
						sel = (loop_i.speed_out > torque_r) ? torque_r : loop_i.speed_out;
				end
				else
					sel = ZERO_D;
				regen = (loop_i.speed_fb[DW-1] != torque_r[DW-1]) && loop_i.speed_fb != ZERO_D;
				// Regenerating below the speed demand loses its torque demand.
				if (regen && (loop_i.speed_fb[DW-1] ? (loop_i.speed_fb > loop_i.speed_dem)
				                                  : (loop_i.speed_fb < loop_i.speed_dem)))
					sel = ZERO_D;
				// Motoring past the speed demand sees an opposed error and drops to zero.
				if (!regen && loop_i.speed_err != ZERO_D && loop_i.speed_err[DW-1] != torque_r[DW-1])
					sel = ZERO_D;
			end
			CDL_COILER:
			begin
				if (torque_r != ZERO_D && loop_i.speed_fb != ZERO_D
				    && torque_r[DW-1] != loop_i.speed_fb[DW-1])
				begin
					zero_ref_nxt  = 1'b1;
					speed_ref_nxt = ZERO_D;
				end
				sel = loop_i.speed_out;
			end
			default:
				sel = loop_i.speed_out;
		endcase
		demand_nxt = sel;
		if (trim_sel_r)
			demand_nxt = sat({{2{sel[DW-1]}}, sel} + {{2{trim_r[DW-1]}}, trim_r});
		// Positive demand meets the positive bridge limit, negative demand the negative one.
		plim = $signed({1'b0, umin(over_nxt, pos_lim_r)});
		nlim = $signed({1'b0, umin(over_nxt, neg_lim_r)});
		final_nxt = demand_nxt;
		if (demand_nxt > plim)
			final_nxt = plim;
		else if (demand_nxt < -nlim)
			final_nxt = -nlim;
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			demand_r <= ZERO_D;
			final_r  <= ZERO_D;
			over_r   <= '0;
		end
		else
		begin
			demand_r <= demand_nxt;
			final_r  <= final_nxt;
			over_r   <= over_nxt;
		end
	end

	// The speed reference goes back upstream, so it is registered like the demand.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			speed_ref_o      <= ZERO_D;
			zero_speed_ref_o <= 1'b0;
		end
		else
		begin
			speed_ref_o      <= speed_ref_nxt;
			zero_speed_ref_o <= zero_ref_nxt;
		end
	end

	assign final_demand_o = final_r;

	// Read data return to zero outside the read cycle so an idle port reads as zero.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
		begin
			case (addr_i)
				A_DEMAND:    rdata_o <= {{5{demand_r[DW-1]}}, demand_r};
				A_FINAL:     rdata_o <= {{5{final_r[DW-1]}}, final_r};
				A_OVERRIDE:  rdata_o <= {6'h00, over_r};
				A_SYM_LIM:   rdata_o <= {6'h00, sym_lim_r};
				A_POS_LIM:   rdata_o <= {6'h00, pos_lim_r};
				A_NEG_LIM:   rdata_o <= {6'h00, neg_lim_r};
				A_LIM2:      rdata_o <= {6'h00, lim2_r};
				A_TORQUE:    rdata_o <= {{5{torque_r[DW-1]}}, torque_r};
				A_TRIM:      rdata_o <= {{5{trim_r[DW-1]}}, trim_r};
				A_LIM2_SEL:  rdata_o <= {15'h0000, lim2_sel_r};
				A_TRIM_SEL:  rdata_o <= {15'h0000, trim_sel_r};
				A_MODE_LO:   rdata_o <= {15'h0000, mode_lo_r};
				A_MODE_HI:   rdata_o <= {15'h0000, mode_hi_r};
				A_AUTO_EN:   rdata_o <= {15'h0000, auto_en_r};
				A_LIM2_TIME: rdata_o <= {8'h00, lim2_time_r};
				default:     rdata_o <= 16'h0000;
			endcase
		end
		else
			rdata_o <= 16'h0000;
	end

endmodule

//--- rtl/cdl_pkg.sv
// Package for the current demand select and limit stage.
// Assumes a 40 MHz system clock and a one-cycle register port.
package cdl_pkg;

	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned TICK_S        = 1;
	localparam int unsigned CYC_PER_S     = CLK_HZ * TICK_S;

	localparam int          DW            = 11;
	localparam int          LW            = 10;
	localparam logic signed [DW-1:0] DMAX = 11'sh3E8;
	localparam logic signed [DW-1:0] DMIN = -11'sh3E8;
	localparam logic [LW-1:0] LIM_RST     = 10'h3E8;
	localparam logic [DW-1:0] ZERO_D      = 11'h000;

	localparam logic [4:0] A_DEMAND       = 5'h01;
	localparam logic [4:0] A_FINAL        = 5'h02;
	localparam logic [4:0] A_OVERRIDE     = 5'h03;
	localparam logic [4:0] A_SYM_LIM      = 5'h04;
	localparam logic [4:0] A_POS_LIM      = 5'h05;
	localparam logic [4:0] A_NEG_LIM      = 5'h06;
	localparam logic [4:0] A_LIM2         = 5'h07;
	localparam logic [4:0] A_TORQUE       = 5'h08;
	localparam logic [4:0] A_TRIM         = 5'h09;
	localparam logic [4:0] A_LIM2_SEL     = 5'h0A;
	localparam logic [4:0] A_TRIM_SEL     = 5'h0B;
	localparam logic [4:0] A_MODE_LO      = 5'h0C;
	localparam logic [4:0] A_MODE_HI      = 5'h0D;
	localparam logic [4:0] A_AUTO_EN      = 5'h12;
	localparam logic [4:0] A_LIM2_TIME    = 5'h13;

	typedef enum logic [1:0] {
		CDL_SPEED    = 2'h0,
		CDL_TORQUE   = 2'h1,
		CDL_OVERRIDE = 2'h2,
		CDL_COILER   = 2'h3
	} cdl_mode_t;

	typedef struct packed {
		logic signed [DW-1:0] speed_out;
		logic signed [DW-1:0] speed_err;
		logic signed [DW-1:0] speed_fb;
		logic signed [DW-1:0] speed_dem;
		logic        [LW-1:0] taper_lim;
	} cdl_loop_in_t;

endpackage

//--- testbench/cdl_sva.sv
// Port checker for the current demand stage, bound into the design.
// Assumes read data follow a read strobe by one cycle.
`timescale 1ns/1ps
module cdl_sva
	import cdl_pkg::*;
(
	input wire logic                 clk_sys_i,
	input wire logic                 rstn_i,
	input wire logic [4:0]           addr_i,
	input wire logic                 rd_i,
	input wire logic [15:0]          rdata_o,
	input wire cdl_loop_in_t         loop_i,
	input wire logic signed [DW-1:0] final_demand_o,
	input wire logic signed [DW-1:0] speed_ref_o,
	input wire logic                 zero_speed_ref_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data not idle");
	property p_fin; $past(rd_i) && $past(addr_i) == A_FINAL |-> rdata_o[10:0] == $past(final_demand_o); endproperty
	a_fin: assert property (p_fin) else $error("final readback differs");
	property p_rng; final_demand_o <= DMAX && final_demand_o >= DMIN; endproperty
	a_rng: assert property (p_rng) else $error("demand out of range");
	property p_tap; int'(final_demand_o) <= int'($past(loop_i.taper_lim))
		&& -int'(final_demand_o) <= int'($past(loop_i.taper_lim)); endproperty
	a_tap: assert property (p_tap) else $error("demand above taper limit");
	property p_sref; !zero_speed_ref_o |-> speed_ref_o == $past(loop_i.speed_dem); endproperty
	a_sref: assert property (p_sref) else $error("speed ref not passed");
	property p_zref; zero_speed_ref_o |-> speed_ref_o == ZERO_D; endproperty
	a_zref: assert property (p_zref) else $error("speed ref not zero");
	property p_sym; $past(rd_i) && $past(addr_i) == A_SYM_LIM |-> rdata_o <= 16'h03E8; endproperty
	a_sym: assert property (p_sym) else $error("limit above range");
	property p_sel; $past(rd_i) && $past(addr_i) == A_LIM2_SEL |-> rdata_o[15:1] == 15'h0000; endproperty
	a_sel: assert property (p_sel) else $error("select not one bit");
	property p_ovr; $past(rd_i) && $past(addr_i) == A_OVERRIDE
		|-> rdata_o <= {6'h00, $past(loop_i.taper_lim, 2)}; endproperty
	a_ovr: assert property (p_ovr) else $error("over-riding limit above taper");
endmodule
bind cdl_select_limit cdl_sva u_cdl_sva (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .loop_i(loop_i), .final_demand_o(final_demand_o), .speed_ref_o(speed_ref_o),
	.zero_speed_ref_o(zero_speed_ref_o));

//--- testbench/cdl_loop_model.sv
// Upstream speed loop stand-in feeding the loop inputs of the stage.
// Assumes the bench sets targets on the rising clock edge.
`timescale 1ns/1ps
module cdl_loop_model
	import cdl_pkg::*;
(
	input  wire logic         clk_sys_i,
	input  wire logic         rstn_i,
	input  wire cdl_loop_in_t tgt_i,
	output cdl_loop_in_t      loop_o
);
	// Registered like a real loop; standstill logic is taken as held off in torque modes.
	always_ff @(posedge clk_sys_i or negedge rstn_i)
		if (!rstn_i)
			loop_o <= '0;
		else
			loop_o <= tgt_i;
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the current demand select and limit stage.
// Assumes a second shortened to ten clocks and the loop model upstream.
`timescale 1ns/1ps
module testbench
	import cdl_pkg::*;
;
	logic                 clk_sys_i = 1'b0;
	logic                 rstn_i = 1'b0;
	logic [4:0]           addr_i = 5'h00;
	logic [15:0]          wdata_i = 16'h0000;
	logic                 wr_i = 1'b0;
	logic                 rd_i = 1'b0;
	logic                 run_i = 1'b0;
	logic [15:0]          rdata_o;
	cdl_loop_in_t         tgt = '0;
	cdl_loop_in_t         loop_i;
	logic signed [DW-1:0] final_demand_o;
	logic signed [DW-1:0] speed_ref_o;
	logic                 zero_speed_ref_o;
	int                   mismatches = 0;
	int                   checks = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	cdl_loop_model u_cdl_loop_model (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .tgt_i(tgt), .loop_o(loop_i));
	cdl_select_limit #(.SEC_CYCLES(10)) u_cdl_select_limit (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .loop_i(loop_i),
		.run_i(run_i), .final_demand_o(final_demand_o), .speed_ref_o(speed_ref_o),
		.zero_speed_ref_o(zero_speed_ref_o));
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask
	task automatic ld(input logic [10:0] so, se, fb, sd, input logic [9:0] tp);
		@(posedge clk_sys_i);
		tgt <= '{so, se, fb, sd, tp};
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic t_defaults;
		for (int a = 4; a < 14; a++)
			rc(a[4:0], a < 8 ? 16'h03E8 : 16'h0000);
		rc(A_AUTO_EN, 16'h0000);
		rc(A_LIM2_TIME, 16'h0000);
	endtask
	task automatic t_speed;
		ld(11'h1F4, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h1F4);
		rc(A_FINAL, 16'h01F4);
		wr(A_POS_LIM, 16'h0258);
		ld(11'h3E8, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h258);
		rc(A_DEMAND, 16'h03E8);
		wr(A_NEG_LIM, 16'h012C);
		ld(-11'sh384, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, -11'sh12C);
		wr(A_SYM_LIM, 16'h0190);
		ld(11'h3E8, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h190);
		wr(A_SYM_LIM, 16'h07D0);
		rc(A_SYM_LIM, 16'h03E8);
	endtask
	task automatic t_lim2;
		wr(A_LIM2, 16'h00C8);
		ld(11'h1F4, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h1F4);
		wr(A_LIM2_SEL, 16'h0001);
		ld(11'h1F4, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h0C8);
		ld(-11'sh1F4, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, -11'sh0C8);
		ld(11'h1F4, '0, '0, '0, 10'h096);
		chk(final_demand_o, 11'h096);
		rc(A_OVERRIDE, 16'h0096);
		wr(A_LIM2_SEL, 16'h0000);
	endtask
	task automatic t_trim;
		wr(A_POS_LIM, 16'h03E8);
		wr(A_TRIM, 16'h0064);
		ld(11'h3B6, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h3B6);
		wr(A_TRIM_SEL, 16'h0001);
		ld(11'h3B6, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h3E8);
		wr(A_TRIM_SEL, 16'h0000);
	endtask
	task automatic t_torque;
		wr(A_TORQUE, 16'h012C);
		wr(A_MODE_LO, 16'h0001);
		ld(-11'sh1F4, '0, '0, '0, 10'h3E8);
		chk(final_demand_o, 11'h12C);
		wr(A_TORQUE, 16'h0320);
		ld(-11'sh1F4, '0, '0, '0, 10'h258);
		chk(final_demand_o, 11'h258);
		wr(A_MODE_LO, 16'h0000);
	endtask
	task automatic t_override;
		wr(A_TORQUE, 16'h012C);
		wr(A_MODE_HI, 16'h0001);
		ld(11'h320, 11'h032, 11'h064, '0, 10'h3E8);
		chk(final_demand_o, 11'h12C);
		ld(11'h064, 11'h032, 11'h064, '0, 10'h3E8);
		chk(final_demand_o, 11'h064);
		ld(11'h320, -11'sh032, 11'h064, '0, 10'h3E8);
		chk(final_demand_o, 11'h000);
		ld(11'h320, 11'h032, -11'sh064, -11'sh190, 10'h3E8);
		chk(final_demand_o, 11'h000);
		ld(11'h320, 11'h032, -11'sh1F4, -11'sh190, 10'h3E8);
		chk(final_demand_o, 11'h12C);
		wr(A_TORQUE, -11'sh12C);
		ld(-11'sh320, -11'sh032, -11'sh064, '0, 10'h3E8);
		chk(final_demand_o, -11'sh12C);
	endtask
	task automatic t_coiler;
		wr(A_TORQUE, -11'sh0C8);
		wr(A_MODE_LO, 16'h0001);
		ld('0, '0, 11'h064, 11'h190, 10'h3E8);
		chk(zero_speed_ref_o, 16'h0001);
		chk(speed_ref_o, 11'h000);
		ld('0, '0, -11'sh064, 11'h190, 10'h3E8);
		chk(speed_ref_o, 11'h190);
		chk(zero_speed_ref_o, 16'h0000);
	endtask
	task automatic t_auto;
		wr(A_AUTO_EN, 16'h0001);
		wr(A_LIM2_TIME, 16'h0002);
		@(posedge clk_sys_i);
		run_i <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		rc(A_LIM2_SEL, 16'h0000);
		repeat (20) @(posedge clk_sys_i);
		rc(A_LIM2_SEL, 16'h0001);
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		run_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_defaults;
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		t_defaults;
		t_speed;
		t_lim2;
		t_trim;
		t_torque;
		t_override;
		t_coiler;
		t_auto;
		summarize;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		summarize;
	end
endmodule
